// ---- design/host_bus_interrupt_requester.sv ----
// Summary of operation
// - request when enable, special condition, idle
// - request on idle rising with enable set
// - request when software writes enable and idle
// - drive only the jumper-selected request level
// - grant absorbed while request pending, no dma request, grant not already passed on
// - select acknowledge about 100 ns after grant
// - select acknowledge withdraws request level
// - take bus when grant, busy, sync clear
// - owning bus clears select acknowledge
// - while owning, later grants pass downstream
// - owner drives busy, strobe and vector
// - vector bits come from link inputs
// - slave sync accepts vector, clears enable
// - dropped request releases bus and vector
// - indicators show grant, acknowledge, busy
`timescale 1ns/1ps
`include "irq_req_cfg.svh"

module host_bus_interrupt_requester
(
    // clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_N_I,
    input  wire logic                   CE_I,
    input  wire logic                   BUS_INIT_I,
    // control and status bits
    input  wire logic                   IE_SET_I,
    input  wire logic                   IE_VALUE_I,
    input  wire logic                   SPECIAL_CONDITION_I,
    input  wire logic                   CONTROLLER_IDLE_I,
    input  wire logic                   CSF_WRITE_I,
    input  wire logic                   CSF_WR_IE_I,
    input  wire logic                   CSF_WR_IDLE_I,
    // jumpers
    input  wire logic [1:0]             LEVEL_SEL_I,
    input  wire logic [`VECTOR_W-1:0]   VECTOR_LINK_I,
    // bus handshake in
    input  wire logic                   BUS_GRANT_IN_I,
    input  wire logic                   BUS_BUSY_IN_I,
    input  wire logic                   SLAVE_SYNC_I,
    input  wire logic                   DMA_REQUEST_LINE_I,
    // bus handshake out
    output logic [`LEVEL_CNT-1:0]       BUS_REQUEST_O,
    output logic                        SELECT_ACK_O,
    output logic                        BUS_OCCUPIED_O,
    output logic                        VECTOR_STROBE_O,
    output logic [`VECTOR_W-1:0]        VECTOR_O,
    output logic                        GRANT_OUT_O,
    // status
    output logic                        INTERRUPT_ENABLE_O,
    output logic                        PENDING_IRQ_O,
    output logic                        VECTOR_ACCEPTED_O,
    // indicators
    output logic                        LED_GRANT_O,
    output logic                        LED_SELECT_ACKNOWLEDGE_O,
    output logic                        LED_BUSY_O
);

    irq_req_pkg::state_s s_r;
    irq_req_pkg::state_s s_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic       raise;
        logic       grant_ok;
        logic [3:0] lvl;
        raise    = 1'b0;
        grant_ok = 1'b0;
        lvl      = 4'h0;
        s_nxt    = s_r;
        s_nxt.accepted = 1'b0;
        s_nxt.idle_d   = CONTROLLER_IDLE_I;

        if (IE_SET_I)
        begin
            s_nxt.ie = IE_VALUE_I;
        end

        if (s_r.ie && SPECIAL_CONDITION_I && CONTROLLER_IDLE_I)
        begin
            raise = 1'b1;
        end
        if (s_r.ie && CONTROLLER_IDLE_I && !s_r.idle_d)
        begin
            raise = 1'b1;
        end
        if (CSF_WRITE_I && CSF_WR_IE_I && CSF_WR_IDLE_I)
        begin
            raise    = 1'b1;
            s_nxt.ie = 1'b1;
        end
        if (raise)
        begin
            s_nxt.irq_flag = 1'b1;
        end

        case (s_r.phase)
            irq_req_pkg::ST_IDLE:
            begin
                s_nxt.select_acknowledge_cnt = 3'h0;
                // grant absorbed
                // a dma request upstream means the grant is not ours to keep
                if (s_r.pending_irq && BUS_GRANT_IN_I && !s_r.pass_on
                    && !DMA_REQUEST_LINE_I)
                begin
                    s_nxt.phase = irq_req_pkg::ST_WAIT_SELECT_ACKNOWLEDGE;
                end
            end
            irq_req_pkg::ST_WAIT_SELECT_ACKNOWLEDGE:
            begin
                // deskew delay
                // a grant already passed on must never be acknowledged too
                if (!BUS_GRANT_IN_I || s_r.pass_on)
                begin
                    s_nxt.phase = irq_req_pkg::ST_IDLE;
                end
                else if (s_r.select_acknowledge_cnt >= 3'(`SELECT_ACKNOWLEDGE_DELAY_CYC - 1))
                begin
                    s_nxt.phase       = irq_req_pkg::ST_WAIT_BUS;
                    s_nxt.bus.sel_ack = 1'b1;
                end
                else
                begin
                    s_nxt.select_acknowledge_cnt = s_r.select_acknowledge_cnt + 3'h1;
                end
            end
            irq_req_pkg::ST_WAIT_BUS:
            begin
                // wait for previous cycle to end
                grant_ok = !BUS_GRANT_IN_I && !BUS_BUSY_IN_I && !SLAVE_SYNC_I;
                if (grant_ok)
                begin
                    s_nxt.phase = irq_req_pkg::ST_MASTER;
                    s_nxt.bus.sel_ack = 1'b0;
                end
            end
            irq_req_pkg::ST_MASTER:
            begin
                // vector accepted
                // sync outlasts the strobe by a cycle: accept only once
                if (SLAVE_SYNC_I && s_r.bus.vec_strobe && s_r.pending_irq)
                begin
                    s_nxt.accepted = 1'b1;
                    s_nxt.ie       = 1'b0;
                    s_nxt.irq_flag = 1'b0;
                end
                if (!s_r.pending_irq)
                begin
                    s_nxt.phase = irq_req_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.phase = irq_req_pkg::ST_IDLE;
            end
        endcase

        s_nxt.pending_irq = s_nxt.irq_flag && s_nxt.ie;

        if (s_r.phase == irq_req_pkg::ST_MASTER || DMA_REQUEST_LINE_I
            || !s_r.pending_irq)
        begin
            s_nxt.pass_on = BUS_GRANT_IN_I;
        end
        else if (!BUS_GRANT_IN_I)
        begin
            s_nxt.pass_on = 1'b0;
        end

        if (s_nxt.pending_irq && !s_nxt.bus.sel_ack
            && s_nxt.phase != irq_req_pkg::ST_MASTER)
        begin
            lvl[LEVEL_SEL_I] = 1'b1;
        end
        s_nxt.bus.req_level = lvl;

        s_nxt.bus.busy       = s_nxt.phase == irq_req_pkg::ST_MASTER;
        s_nxt.bus.vec_strobe = s_nxt.bus.busy;
        s_nxt.bus.vector     = s_nxt.bus.busy ? VECTOR_LINK_I : 7'h00;
        s_nxt.bus.grant_out  = s_nxt.pass_on;

        s_nxt.leds.led_grant = BUS_GRANT_IN_I;
        s_nxt.leds.led_select_acknowledge  = s_nxt.bus.sel_ack;
        s_nxt.leds.led_busy  = s_nxt.bus.busy;

        if (BUS_INIT_I)
        begin
            s_nxt = '0;
            s_nxt.phase = irq_req_pkg::ST_IDLE;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_r <= '0;
        end
        else if (CE_I)
        begin
            s_r <= s_nxt;
        end
    end

    assign BUS_REQUEST_O      = s_r.bus.req_level;
    assign SELECT_ACK_O       = s_r.bus.sel_ack;
    assign BUS_OCCUPIED_O     = s_r.bus.busy;
    assign VECTOR_STROBE_O    = s_r.bus.vec_strobe;
    assign VECTOR_O           = s_r.bus.vector;
    assign GRANT_OUT_O        = s_r.bus.grant_out;
    assign INTERRUPT_ENABLE_O = s_r.ie;
    assign PENDING_IRQ_O      = s_r.pending_irq;
    assign VECTOR_ACCEPTED_O  = s_r.accepted;
    assign LED_GRANT_O        = s_r.leds.led_grant;
    assign LED_SELECT_ACKNOWLEDGE_O         = s_r.leds.led_select_acknowledge;
    assign LED_BUSY_O         = s_r.leds.led_busy;

endmodule

// ---- design/irq_req_cfg.svh ----
`ifndef IRQ_REQ_CFG_SVH
`define IRQ_REQ_CFG_SVH

// request levels 4..7, level five is index 1
`define LEVEL_CNT          4
`define LEVEL_DEFAULT_SEL  2'h1
`define VECTOR_W           7
`define VECTOR_DEFAULT     7'h70
// grant to select-acknowledge delay
`define SELECT_ACKNOWLEDGE_DELAY_NS      100
`define CLK_PERIOD_NS      20
`define SELECT_ACKNOWLEDGE_DELAY_CYC     ((`SELECT_ACKNOWLEDGE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELECT_ACKNOWLEDGE_CNT_W         3

`endif

// ---- design/irq_req_pkg.sv ----
package irq_req_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_SELECT_ACKNOWLEDGE,
        ST_WAIT_BUS,
        ST_MASTER
    } phase_e;

    // bus-facing outputs, all from flip-flops
    typedef struct packed {
        logic [3:0] req_level;
        logic       sel_ack;
        logic       busy;
        logic       vec_strobe;
        logic [6:0] vector;
        logic       grant_out;
    } bus_out_s;

    typedef struct packed {
        logic led_grant;
        logic led_select_acknowledge;
        logic led_busy;
    } leds_s;

    typedef struct packed {
        phase_e     phase;
        logic       pending_irq;
        logic       irq_flag;
        logic       ie;
        logic       idle_d;
        logic       pass_on;
        logic [2:0] select_acknowledge_cnt;
        logic       accepted;
        bus_out_s   bus;
        leds_s      leds;
    } state_s;

endpackage

// ---- verification/irq_handshake_asserts.sv ----
`timescale 1ns/1ps
module irq_handshake_chk (
    // bus inputs
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic [1:0] LEVEL_SEL_I,
    input wire logic [6:0] VECTOR_LINK_I,
    input wire logic       BUS_GRANT_IN_I,
    input wire logic       BUS_BUSY_IN_I,
    input wire logic       SLAVE_SYNC_I,
    // block outputs
    input wire logic [3:0] BUS_REQUEST_O,
    input wire logic       SELECT_ACK_O,
    input wire logic       BUS_OCCUPIED_O,
    input wire logic       VECTOR_STROBE_O,
    input wire logic [6:0] VECTOR_O,
    input wire logic       INTERRUPT_ENABLE_O,
    input wire logic       PENDING_IRQ_O,
    input wire logic       VECTOR_ACCEPTED_O
);
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    wire take_ok = SELECT_ACK_O & ~BUS_GRANT_IN_I & ~BUS_BUSY_IN_I & ~SLAVE_SYNC_I;
    a_one_level:
    assert property (|BUS_REQUEST_O |-> BUS_REQUEST_O == 4'h1 << LEVEL_SEL_I)
        else $error("request on wrong level");
    a_select_acknowledge_late:
    assert property ($rose(SELECT_ACK_O) |-> $past(BUS_GRANT_IN_I, 5))
        else $error("acknowledge too early");
    a_select_acknowledge_req:
    assert property (SELECT_ACK_O |-> BUS_REQUEST_O == 4'h0)
        else $error("request kept with acknowledge");
    a_take_bus:
    assert property ($rose(BUS_OCCUPIED_O) |-> $past(take_ok))
        else $error("bus taken too soon");
    a_busy_select_acknowledge:
    assert property (BUS_OCCUPIED_O |-> !SELECT_ACK_O)
        else $error("acknowledge kept as owner");
    a_vec_shown:
    assert property (BUS_OCCUPIED_O |-> VECTOR_STROBE_O && VECTOR_O == VECTOR_LINK_I)
        else $error("vector not shown");
    a_accept_clr:
    assert property (VECTOR_ACCEPTED_O |-> !INTERRUPT_ENABLE_O && !PENDING_IRQ_O)
        else $error("enable kept after accept");
    a_bus_freed:
    assert property (VECTOR_ACCEPTED_O |=> !BUS_OCCUPIED_O && VECTOR_O == 7'h0)
        else $error("bus kept after accept");
endmodule

bind host_bus_interrupt_requester irq_handshake_chk chk (.*);

// ---- verification/bus_arbiter_model.sv ----
`timescale 1ns/1ps
module bus_arbiter_model (
    // handshake from block
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] req_i,
    input  wire logic       select_acknowledge_i,
    input  wire logic       strobe_i,
    input  wire logic       stall_i,
    // answers
    output logic            grant_o,
    output logic            sync_o
);
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            grant_o <= 1'b0;
            sync_o  <= 1'b0;
        end
        else
        begin
            // drop grant on acknowledge
            // later grant for another device while the vector shows
            grant_o <= (|req_i || strobe_i) && !select_acknowledge_i && !stall_i;
            sync_o  <= strobe_i;
        end
endmodule

// ---- verification/test_host_bus_interrupt_requester.sv ----
`timescale 1ns/1ps
module test_host_bus_interrupt_requester;
    logic CLK_I = 0, RST_N_I = 0, CE_I = 1, BUS_INIT_I = 0, IE_SET_I = 0;
    logic IE_VALUE_I = 0, SPECIAL_CONDITION_I = 0, CONTROLLER_IDLE_I = 0;
    logic CSF_WRITE_I = 0, CSF_WR_IE_I = 1, CSF_WR_IDLE_I = 1, stall = 1;
    logic BUS_BUSY_IN_I = 0, DMA_REQUEST_LINE_I = 0;
    logic [1:0] LEVEL_SEL_I = 2'h1;
    logic [6:0] VECTOR_LINK_I = 7'h70, VECTOR_O;
    logic [3:0] BUS_REQUEST_O;
    logic BUS_GRANT_IN_I, SLAVE_SYNC_I, SELECT_ACK_O, BUS_OCCUPIED_O, VECTOR_STROBE_O;
    logic GRANT_OUT_O, INTERRUPT_ENABLE_O, PENDING_IRQ_O, VECTOR_ACCEPTED_O;
    logic LED_GRANT_O, LED_SELECT_ACKNOWLEDGE_O, LED_BUSY_O;
    logic [6:0] exp_q[$];
    int n_fail = 0, cmp_count = 0, cyc = 0;
    logic grant_d = 0, init_d = 1;

    always #10 CLK_I = ~CLK_I;
    host_bus_interrupt_requester dut (.*);
    bus_arbiter_model arb (.clk_i(CLK_I), .rst_n_i(RST_N_I), .req_i(BUS_REQUEST_O),
        .select_acknowledge_i(SELECT_ACK_O), .strobe_i(VECTOR_STROBE_O), .stall_i(stall),
        .grant_o(BUS_GRANT_IN_I), .sync_o(SLAVE_SYNC_I));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // kind 0 special, 1 idle rising, 2 control write
    task automatic run_irq(input int kind, input bit abort, input bit dma);
        logic [1:0] sel;
        logic [6:0] vec;
        sel = 2'($urandom);
        vec = 7'($urandom);
        @(posedge CLK_I);
        LEVEL_SEL_I <= sel;
        VECTOR_LINK_I <= vec;
        BUS_BUSY_IN_I <= 1'b1;
        stall <= 1'b1;
        CONTROLLER_IDLE_I <= (kind != 1);
        IE_SET_I <= 1'b1;
        IE_VALUE_I <= (kind != 2);
        @(posedge CLK_I);
        IE_SET_I <= 1'b0;
        SPECIAL_CONDITION_I <= (kind == 0);
        CONTROLLER_IDLE_I <= 1'b1;
        CSF_WRITE_I <= (kind == 2);
        @(posedge CLK_I);
        CSF_WRITE_I <= 1'b0;
        repeat (9) if (PENDING_IRQ_O !== 1'b1) @(posedge CLK_I);
        check({4'h0, BUS_REQUEST_O}, {4'h0, 4'h1 << sel});
        if (dma)
        begin
            DMA_REQUEST_LINE_I <= 1'b1;
            stall <= 1'b0;
            repeat (4) @(posedge CLK_I);
            check({6'h0, GRANT_OUT_O, SELECT_ACK_O}, 8'h02);
            stall <= 1'b1;
            repeat (3) @(posedge CLK_I);
            DMA_REQUEST_LINE_I <= 1'b0;
        end
        repeat ($urandom % 4) @(posedge CLK_I);
        stall <= 1'b0;
        repeat (20) if (SELECT_ACK_O !== 1'b1) @(posedge CLK_I);
        check({1'b0, GRANT_OUT_O, LED_SELECT_ACKNOWLEDGE_O, SELECT_ACK_O, BUS_REQUEST_O}, 8'h30);
        if (abort)
        begin
            BUS_INIT_I <= 1'b1;
            @(posedge CLK_I);
            BUS_INIT_I <= 1'b0;
            @(posedge CLK_I);
            check({1'b0, BUS_REQUEST_O, SELECT_ACK_O, BUS_OCCUPIED_O, INTERRUPT_ENABLE_O},
                  8'h00);
        end
        else
        begin
            exp_q.push_back(vec);
            repeat ($urandom % 4) @(posedge CLK_I);
            BUS_BUSY_IN_I <= 1'b0;
            repeat (20) if (BUS_OCCUPIED_O !== 1'b1) @(posedge CLK_I);
            check({5'h0, LED_BUSY_O, VECTOR_STROBE_O, BUS_OCCUPIED_O}, 8'h07);
            repeat (20) if (BUS_OCCUPIED_O !== 1'b0) @(posedge CLK_I);
            check(8'(exp_q.size()), 8'h0);
        end
        BUS_BUSY_IN_I <= 1'b0;
        SPECIAL_CONDITION_I <= 1'b0;
    endtask

    always @(posedge CLK_I)
        if (VECTOR_ACCEPTED_O === 1'b1)
        begin
            check({1'b0, VECTOR_O}, {1'b0, exp_q.pop_front()});
            check({6'h0, GRANT_OUT_O, INTERRUPT_ENABLE_O}, 8'h02);
        end

    // indicator follows the grant one edge later
    always @(posedge CLK_I)
    begin
        if (RST_N_I && !init_d)
            check({7'h0, LED_GRANT_O}, {7'h0, grant_d});
        grant_d <= BUS_GRANT_IN_I;
        init_d <= BUS_INIT_I || !RST_N_I;
    end

    always @(posedge CLK_I)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(63846));
        repeat (2) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        for (int i = 0; i < 6; i++)
            run_irq(i % 3, i == 4, i == 3);
        summarize();
    end
endmodule
